/* File: dmx_map.svh */
// Purpose: Constants for the data move instruction executor
// Assumes: 12-bit instruction word, 8-bit data path, 5-bit file address
// Notes on behaviour
// - Opcode 0010 00df ffff copies the addressed file register (0 to 31) to the destination.
// - That move writes the accumulator when d is 0 and the file register itself when d is 1.
// - That move sets the zero flag from the moved value, so a self copy tests for zero.
// - Opcode 1100 kkkk kkkk loads the 8-bit literal into the accumulator, flags unchanged.
// - Opcode 0000 001f ffff stores the accumulator into the addressed file register.
`ifndef DMX_MAP_SVH
`define DMX_MAP_SVH
`define DMX_MOVE_FILE_MASK  12'hFC0
`define DMX_MOVE_FILE_CODE  12'h200
`define DMX_LOAD_LIT_MASK   12'hF00
`define DMX_LOAD_LIT_CODE   12'hC00
`define DMX_STORE_ACC_MASK  12'hFE0
`define DMX_STORE_ACC_CODE  12'h020
`define DMX_OPTION_CODE     12'h002
`define DMX_NOP_CODE        12'h000
`define DMX_DEST_BIT        5
`define DMX_ACC_RESET       8'h00
`define DMX_OPTION_RESET    8'hFF
`endif

/* File: dmx_pkg.sv */
// Purpose: Types for the data move instruction executor
// Assumes: Constants come from dmx_map.svh
// Notes: None
package dmx_pkg;
  typedef enum logic [2:0] {
    DMX_OP_NONE, DMX_OP_MOVE_FILE, DMX_OP_LOAD_LIT, DMX_OP_STORE_ACC, DMX_OP_OPTION
  } dmx_op_e;
  typedef struct packed {
    logic       write;
    logic [4:0] addr;
    logic [7:0] data;
  } dmx_file_wr_s;
  typedef struct packed {
    logic [7:0]   acc;
    logic [7:0]   option;
    logic         zero;
    logic         zero_we;
    dmx_file_wr_s file_wr;
    dmx_op_e      last_op;
  } dmx_state_s;
endpackage : dmx_pkg

/* File: dmx_exec.sv */
// Purpose: Decode and execute move, literal load, store and option load
// Assumes: One instruction per clock; file read data is combinational from i_file_rdata
// Notes: File writes and zero flag updates are registered, one cycle after decode
`include "dmx_map.svh"
`timescale 1ns/1ps
module dmx_exec (
  input  wire logic                  i_clock,
  input  wire logic                  i_resetn,
  input  wire logic                  i_valid,
  input  wire logic [11:0]           i_instr,
  input  wire logic [7:0]            i_file_rdata,
  output logic      [4:0]            o_file_raddr,
  output dmx_pkg::dmx_file_wr_s      o_file_wr,
  output logic      [7:0]            o_acc,
  output logic      [7:0]            o_option,
  output logic                       o_zero,
  output logic                       o_zero_we,
  output dmx_pkg::dmx_op_e           o_last_op
);
  dmx_pkg::dmx_state_s state_reg;
  dmx_pkg::dmx_state_s state_next;
  dmx_pkg::dmx_op_e    op;

  // Read address is the low field of every instruction; decode picks use
  assign o_file_raddr = i_instr[4:0];

  always_comb begin
    op = dmx_pkg::DMX_OP_NONE;
    if (i_valid) begin
      if ((i_instr & `DMX_MOVE_FILE_MASK) == `DMX_MOVE_FILE_CODE) begin
        op = dmx_pkg::DMX_OP_MOVE_FILE;
      end else if ((i_instr & `DMX_LOAD_LIT_MASK) == `DMX_LOAD_LIT_CODE) begin
        op = dmx_pkg::DMX_OP_LOAD_LIT;
      end else if ((i_instr & `DMX_STORE_ACC_MASK) == `DMX_STORE_ACC_CODE) begin
        op = dmx_pkg::DMX_OP_STORE_ACC;
      end else if (i_instr == `DMX_OPTION_CODE) begin
        op = dmx_pkg::DMX_OP_OPTION;
      end
    end
  end

  always_comb begin
    state_next               = state_reg;
    state_next.file_wr.write = 1'b0;
    state_next.zero_we       = 1'b0;
    state_next.last_op       = op;
    case (op)
      dmx_pkg::DMX_OP_MOVE_FILE: begin
        if (i_instr[`DMX_DEST_BIT]) begin
          state_next.file_wr.write = 1'b1;
          state_next.file_wr.addr  = i_instr[4:0];
          state_next.file_wr.data  = i_file_rdata;
        end else begin
          state_next.acc = i_file_rdata;
        end
        state_next.zero    = (i_file_rdata == 8'h00);
        state_next.zero_we = 1'b1;
      end
      dmx_pkg::DMX_OP_LOAD_LIT: begin
        state_next.acc = i_instr[7:0];
      end
      dmx_pkg::DMX_OP_STORE_ACC: begin
        state_next.file_wr.write = 1'b1;
        state_next.file_wr.addr  = i_instr[4:0];
        state_next.file_wr.data  = state_reg.acc;
      end
      dmx_pkg::DMX_OP_OPTION: begin
        state_next.option = state_reg.acc;
      end
      default: begin
        // No operation, unsupported opcode, or idle slot
      end
    endcase
  end

  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      state_reg.acc     <= `DMX_ACC_RESET;
      state_reg.option  <= `DMX_OPTION_RESET;
      state_reg.zero    <= 1'b0;
      state_reg.zero_we <= 1'b0;
      state_reg.file_wr <= '0;
      state_reg.last_op <= dmx_pkg::DMX_OP_NONE;
    end else begin
      state_reg <= state_next;
    end
  end

  assign o_file_wr = state_reg.file_wr;
  assign o_acc     = state_reg.acc;
  assign o_option  = state_reg.option;
  assign o_zero    = state_reg.zero;
  assign o_zero_we = state_reg.zero_we;
  assign o_last_op = state_reg.last_op;

  property p_move_dest;
    @(posedge i_clock) disable iff (!i_resetn)
      (op == dmx_pkg::DMX_OP_MOVE_FILE) |=>
        (o_file_wr.write == $past(i_instr[5])) && o_zero_we;
  endproperty
  move_file_copy_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
    (op == dmx_pkg::DMX_OP_MOVE_FILE && !i_instr[5]) |=> (o_acc == $past(i_file_rdata)))
    else $error("move to accumulator lost data");
  move_dest_select_a: assert property (p_move_dest)
    else $error("move destination wrong");
  move_zero_flag_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
    (op == dmx_pkg::DMX_OP_MOVE_FILE) |=> (o_zero == ($past(i_file_rdata) == 8'h00)))
    else $error("zero flag wrong after move");
  literal_load_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
    (op == dmx_pkg::DMX_OP_LOAD_LIT) |=> (o_acc == $past(i_instr[7:0])) && !o_zero_we)
    else $error("literal load wrong");
  store_acc_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
    (op == dmx_pkg::DMX_OP_STORE_ACC) |=> o_file_wr.write && !o_zero_we
      && (o_file_wr.data == $past(o_acc)) && (o_file_wr.addr == $past(i_instr[4:0])))
    else $error("store of accumulator wrong");
  option_load_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
    (op == dmx_pkg::DMX_OP_OPTION) |=> (o_option == $past(o_acc)) && !o_file_wr.write)
    else $error("option load wrong");
  nop_idle_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
    (i_valid && i_instr == `DMX_NOP_CODE) |=> !o_file_wr.write && !o_zero_we && $stable(o_acc)
      && $stable(o_option))
    else $error("no operation changed state");
  flags_quiet_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
    (op != dmx_pkg::DMX_OP_MOVE_FILE) |=> !o_zero_we && $stable(o_zero))
    else $error("flag touched by non move");

  // Named taking edges, one per kind of transfer, plus the refused idle slot, used by the checks below
  sequence s_move_to_acc;
    (op == dmx_pkg::DMX_OP_MOVE_FILE) && !i_instr[`DMX_DEST_BIT];
  endsequence
  sequence s_move_to_file;
    (op == dmx_pkg::DMX_OP_MOVE_FILE) && i_instr[`DMX_DEST_BIT];
  endsequence
  sequence s_load_literal;
    op == dmx_pkg::DMX_OP_LOAD_LIT;
  endsequence
  sequence s_store_acc;
    op == dmx_pkg::DMX_OP_STORE_ACC;
  endsequence
  sequence s_option_load;
    op == dmx_pkg::DMX_OP_OPTION;
  endsequence
  sequence s_refused;
    !i_valid;
  endsequence

  // Self copy must write the same data back, or a zero test corrupts the file
  property p_move_to_file;
    @(posedge i_clock) disable iff (!i_resetn)
      s_move_to_file |=> o_file_wr.write && (o_file_wr.addr == $past(i_instr[4:0]))
        && (o_file_wr.data == $past(i_file_rdata)) && $stable(o_acc);
  endproperty
  move_file_write_a: assert property (p_move_to_file)
    else $error("move to file register wrong");

  property p_move_to_acc;
    @(posedge i_clock) disable iff (!i_resetn)
      s_move_to_acc |=> !o_file_wr.write && o_zero_we;
  endproperty
  move_acc_nowrite_a: assert property (p_move_to_acc)
    else $error("move to accumulator wrote the file");

  property p_literal_quiet;
    @(posedge i_clock) disable iff (!i_resetn)
      s_load_literal |=> !o_file_wr.write && $stable(o_zero) && $stable(o_option);
  endproperty
  literal_side_effects_a: assert property (p_literal_quiet)
    else $error("literal load touched other state");

  property p_store_quiet;
    @(posedge i_clock) disable iff (!i_resetn)
      s_store_acc |=> $stable(o_acc) && $stable(o_option) && $stable(o_zero);
  endproperty
  store_side_effects_a: assert property (p_store_quiet)
    else $error("store touched other state");

  property p_option_quiet;
    @(posedge i_clock) disable iff (!i_resetn)
      s_option_load |=> $stable(o_acc) && !o_zero_we && $stable(o_zero);
  endproperty
  option_side_effects_a: assert property (p_option_quiet)
    else $error("option load touched other state");

  property p_refused_idle;
    @(posedge i_clock) disable iff (!i_resetn)
      s_refused |=> !o_file_wr.write && !o_zero_we && $stable(o_acc) && $stable(o_option)
        && (o_last_op == dmx_pkg::DMX_OP_NONE);
  endproperty
  idle_slot_quiet_a: assert property (p_refused_idle)
    else $error("idle slot changed state");

  property p_last_op_track;
    @(posedge i_clock) disable iff (!i_resetn)
      i_valid |=> (o_last_op == $past(op));
  endproperty
  last_op_track_a: assert property (p_last_op_track)
    else $error("decoded operation not reported");

  // Any file write must trace back to a store or a move with d set
  property p_write_source;
    @(posedge i_clock) disable iff (!i_resetn)
      o_file_wr.write |-> ($past(op) == dmx_pkg::DMX_OP_STORE_ACC)
        || (($past(op) == dmx_pkg::DMX_OP_MOVE_FILE) && $past(i_instr[5]));
  endproperty
  write_source_a: assert property (p_write_source)
    else $error("file write without a cause");

  property p_zero_source;
    @(posedge i_clock) disable iff (!i_resetn)
      o_zero_we |-> ($past(op) == dmx_pkg::DMX_OP_MOVE_FILE);
  endproperty
  zero_source_a: assert property (p_zero_source)
    else $error("zero flag written without a move");

  property p_raddr_follow;
    @(posedge i_clock) disable iff (!i_resetn)
      o_file_raddr == i_instr[4:0];
  endproperty
  read_addr_follow_a: assert property (p_raddr_follow)
    else $error("file read address wrong");
endmodule : dmx_exec

/* File: dmx_exec_bench.sv */
// Purpose: Self-checking bench for the data move instruction executor
// Assumes: Effects show one edge after the instruction is taken
// Notes: File read data is driven with the instruction, as a register file would
`timescale 1ns/1ps
module dmx_exec_bench;
  logic                  i_clock = 1'b0;
  logic                  i_resetn = 1'b0;
  logic                  i_valid = 1'b0;
  logic [11:0]           i_instr = 12'h000;
  logic [7:0]            i_file_rdata = 8'h00;
  logic [4:0]            o_file_raddr;
  dmx_pkg::dmx_file_wr_s o_file_wr;
  logic [7:0]            o_acc;
  logic [7:0]            o_option;
  logic                  o_zero;
  logic                  o_zero_we;
  dmx_pkg::dmx_op_e      o_last_op;
  int                    fails = 0;
  int                    compares = 0;
  always #5 i_clock = ~i_clock;
  dmx_exec u_dut (.i_clock(i_clock), .i_resetn(i_resetn), .i_valid(i_valid),
    .i_instr(i_instr), .i_file_rdata(i_file_rdata), .o_file_raddr(o_file_raddr),
    .o_file_wr(o_file_wr), .o_acc(o_acc), .o_option(o_option), .o_zero(o_zero),
    .o_zero_we(o_zero_we), .o_last_op(o_last_op));
  task give_verdict;
    $display("fails=%0d compares=%0d", fails, compares);
    if (fails == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : give_verdict
  task chk(input logic [13:0] g, input logic [13:0] e);
    compares++;
    if (g !== e) begin
      fails++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  // Leaves i_valid high so back to back steps never drive it twice at one time
  task step(input logic [11:0] ins, input logic [7:0] rd);
    i_valid = 1'b1;
    i_instr = ins;
    i_file_rdata = rd;
    #1 chk(14'(o_file_raddr), 14'(ins[4:0]));
    @(posedge i_clock);
    #1;
  endtask : step
  task t_reset;
    chk({14'(o_acc)}, 14'h0000);
    chk(14'(o_option), 14'h00FF);
    chk(14'({o_zero, o_zero_we, o_file_wr.write}), 14'h0000);
  endtask : t_reset
  task t_literal;
    step(12'hC5A, 8'h00);
    chk(14'(o_acc), 14'h005A);
    chk(14'(o_last_op), 14'(dmx_pkg::DMX_OP_LOAD_LIT));
    step(12'hC00, 8'h00);
    chk(14'({o_acc, o_zero, o_zero_we}), 14'h0000);
  endtask : t_literal
  task t_store;
    step(12'hC3C, 8'h00);
    step(12'h025, 8'h77);
    chk(o_file_wr, {1'b1, 5'h05, 8'h3C});
    step(12'h03F, 8'h00);
    chk(o_file_wr, {1'b1, 5'h1F, 8'h3C});
    chk(14'({o_zero, o_zero_we}), 14'h0000);
  endtask : t_store
  task t_move;
    step(12'h211, 8'h00);
    chk(14'({o_acc, o_zero, o_zero_we, o_file_wr.write}), 14'h0006);
    step(12'h21F, 8'h80);
    chk(14'({o_acc, o_zero, o_zero_we}), 14'h0201);
    step(12'h23E, 8'h00);
    chk(o_file_wr, {1'b1, 5'h1E, 8'h00});
    chk(14'({o_acc, o_zero}), 14'h0101);
  endtask : t_move
  task t_option;
    step(12'hC07, 8'h00);
    step(12'h002, 8'h00);
    chk(14'(o_option), 14'h0007);
    step(12'h000, 8'h00);
    chk(14'({o_option, o_acc}), 14'h0707);
    chk(14'({o_zero_we, o_file_wr.write}), 14'h0000);
    chk(14'(o_last_op), 14'(dmx_pkg::DMX_OP_NONE));
  endtask : t_option
  task t_refused;
    i_valid = 1'b0;
    i_instr = 12'hC99;
    @(posedge i_clock);
    #1 chk(14'({o_acc, o_last_op}), 14'h0038);
    step(12'h003, 8'h00);
    chk(14'({o_acc, o_zero_we, o_file_wr.write}), 14'h001C);
  endtask : t_refused
  initial begin
    repeat (16) @(posedge i_clock);
    #1 i_resetn = 1'b1;
    t_reset();
    t_literal();
    t_store();
    t_move();
    t_option();
    t_refused();
    give_verdict();
  end
  // Whole run needs well under 100 cycles
  initial begin
    #20000;
    fails++;
    give_verdict();
  end
endmodule : dmx_exec_bench
